// ### hw/mcc_pkg.sv
// constants for the mac control word block
package mcc_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] CTRL_IDX = 6'h02;
  localparam int B_TX_ON = 0;
  localparam int B_RX_ON = 1;
  localparam int B_RESUME = 2;
  localparam int B_GIG = 3;
  localparam int B_ACCEPT_ALL = 4;
  localparam int B_PAD_STRIP = 5;
  localparam int B_FCS_KEEP = 6;
  localparam int B_PAUSE_PASS = 7;
  localparam int B_SOFT_RST = 13;
  localparam int B_LOOPBACK = 15;
  localparam int B_STATS_CLR = 31;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RSVD_MASK = 32'h7800_0000;
  localparam logic [31:0] SELF_CLR_MASK = 32'h8000_2000;
  localparam logic [15:0] RESUME_QUANTA = 16'h0000;
  localparam logic [15:0] STOP_QUANTA = 16'hffff;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 11;
  localparam int STOP_LEVEL = 12;
endpackage : mcc_pkg

// ### hw/mcc_ctrl.sv
// mac control word, receive frame filter and receive fifo
//
// How it works
// - the 32-bit control word sits at dword index 0x02 with its fields at fixed bits.
// - enables act from the cycle after the write, so software sets them last.
// - bit 0 turns the transmit path on and resets to zero.
// - bit 1 turns the receive path on and resets to zero.
// - hardware reset or a soft reset write clears both enable bits.
// - with resume-pause and transmit enable set, a pause request with quanta zero goes out whatever the fifo level.
// - with gigabit select set, gigabit mode holds and the request input is ignored.
// - with gigabit select clear, gigabit mode follows the request input, else 10/100.
// - with accept-all set, every received frame goes to the user with no address filter.
// - with pad strip set, receive padding is removed and transmit is untouched.
// - in the small variant pad strip and gigabit select have no effect.
// - the gigabit status output is high exactly while running at gigabit speed.
// - fcs keep set passes the frame check field; clear removes it.
// - a padded frame with pad strip on loses both padding and check field regardless of fcs keep.
`timescale 1ns/100ps

module mcc_fifo #(
  parameter int W = 11,
  parameter int D = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [$clog2(D):0] level_o
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] cnt_q;
  logic [PW:0] cnt_d;
  logic in_ready_q;
  logic out_valid_q;
  logic push;
  logic pop;

  initial begin
    if (D < 2 || (1 << PW) != D) begin
      $error("fifo depth must be a power of two of at least 2");
    end
  end

  assign push = in_valid_i & in_ready_q;
  assign pop = out_ready_i & out_valid_q;
  assign in_ready_o = in_ready_q;
  assign out_valid_o = out_valid_q;
  assign out_data_o = mem_q[rd_ptr_q];
  assign level_o = cnt_q;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q + PW'(push);
      rd_ptr_q <= rd_ptr_q + PW'(pop);
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != (PW+1)'(D));
      out_valid_q <= (cnt_d != '0);
    end
  end
endmodule : mcc_fifo

module mcc_ctrl #(
  parameter bit SMALL_MAC = 1'b0,
  parameter int DEPTH = mcc_pkg::FIFO_DEPTH,
  parameter int STOP_AT = mcc_pkg::STOP_LEVEL
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [mcc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic gig_request_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_sop_i,
  input wire logic rx_eop_i,
  input wire logic rx_addr_hit_i,
  input wire logic rx_is_pad_i,
  input wire logic rx_is_fcs_i,
  input wire logic rx_padded_i,
  output logic rx_ready_o,
  output logic [7:0] usr_data_o,
  output logic usr_sop_o,
  output logic usr_eop_o,
  output logic usr_void_o,
  output logic usr_valid_o,
  input wire logic usr_ready_i,
  output logic transmit_path_on_o,
  output logic receive_path_on_o,
  output logic gig_mode_o,
  output logic pause_send_o,
  output logic [15:0] pause_quanta_o,
  output logic loopback_on_o,
  output logic statistics_clear_o
);
  import mcc_pkg::*;

  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] rdata_q;
  logic gig_q;
  logic pause_q;
  logic [15:0] quanta_q;
  logic stats_q;
  logic keep_q;
  logic padded_q;
  logic keep_now;
  logic padded_now;
  logic fire;
  logic drop;
  logic push;
  logic pad_strip_on;
  logic [FIFO_W-1:0] fifo_out;
  logic [$clog2(DEPTH):0] level;

  initial begin
    if (STOP_AT < 1 || STOP_AT > DEPTH) begin
      $error("stop level must lie between 1 and the fifo depth");
    end
  end

  function automatic logic ctrl_hit(input logic [ADDR_W-1:0] a);
    ctrl_hit = (a == CTRL_IDX);
  endfunction : ctrl_hit

  // field store, reserved and self-clearing bits dropped
  always_comb begin
    ctrl_d = reg_wdata_i & ~RSVD_MASK & ~SELF_CLR_MASK;
    if (reg_wdata_i[B_SOFT_RST]) begin
      ctrl_d[B_TX_ON] = 1'b0;
      ctrl_d[B_RX_ON] = 1'b0;
    end
  end

  // zero after reset, enables written directly
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
    end else if (reg_wr_i && ctrl_hit(reg_addr_i)) begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i && ctrl_hit(reg_addr_i)) begin
      rdata_q <= ctrl_q;
    end else begin
      rdata_q <= '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      stats_q <= 1'b0;
    end else begin
      stats_q <= reg_wr_i & ctrl_hit(reg_addr_i) & reg_wdata_i[B_STATS_CLR];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gig_q <= 1'b0;
    end else begin
      gig_q <= (ctrl_q[B_GIG] & ~SMALL_MAC) | gig_request_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pause_q <= 1'b0;
      quanta_q <= STOP_QUANTA;
    end else begin
      pause_q <= ctrl_q[B_TX_ON] &
                 (ctrl_q[B_RESUME] | (32'(level) >= STOP_AT));
      quanta_q <= ctrl_q[B_RESUME] ? RESUME_QUANTA : STOP_QUANTA;
    end
  end

  // frame admission at its first byte
  assign fire = rx_valid_i & rx_ready_o;
  assign keep_now = rx_sop_i ?
    (ctrl_q[B_RX_ON] & (ctrl_q[B_ACCEPT_ALL] | rx_addr_hit_i)) : keep_q;
  assign padded_now = rx_sop_i ? rx_padded_i : padded_q;
  // pad strip absent in small variant
  assign pad_strip_on = ctrl_q[B_PAD_STRIP] & ~SMALL_MAC;

  assign drop = (rx_is_pad_i & pad_strip_on) |
    (rx_is_fcs_i & (~ctrl_q[B_FCS_KEEP] | (padded_now & pad_strip_on)));
  assign push = fire & keep_now & (~drop | rx_eop_i);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      keep_q <= 1'b0;
      padded_q <= 1'b0;
    end else if (fire) begin
      keep_q <= keep_now & ~rx_eop_i;
      padded_q <= padded_now;
    end
  end

  mcc_fifo #(
    .W(FIFO_W),
    .D(DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_data_i({drop, rx_eop_i, rx_sop_i, rx_data_i}),
    .in_valid_i(push),
    .in_ready_o(rx_ready_o),
    .out_data_o(fifo_out),
    .out_valid_o(usr_valid_o),
    .out_ready_i(usr_ready_i),
    .level_o(level)
  );

  assign usr_data_o = fifo_out[7:0];
  assign usr_sop_o = fifo_out[8];
  assign usr_eop_o = fifo_out[9];
  assign usr_void_o = fifo_out[10];
  assign reg_rdata_o = rdata_q;
  // enables act straight from the word
  assign transmit_path_on_o = ctrl_q[B_TX_ON];
  assign receive_path_on_o = ctrl_q[B_RX_ON];
  assign loopback_on_o = ctrl_q[B_LOOPBACK];
  assign gig_mode_o = gig_q;
  assign pause_send_o = pause_q;
  assign pause_quanta_o = quanta_q;
  assign statistics_clear_o = stats_q;

  sequence s_ctrl_wr;
    reg_wr_i && ctrl_hit(reg_addr_i);
  endsequence

  sequence s_ctrl_rd;
    reg_rd_i && ctrl_hit(reg_addr_i);
  endsequence

  chk_soft_reset_clear: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_ctrl_wr ##0 reg_wdata_i[B_SOFT_RST] |=>
      !transmit_path_on_o && !receive_path_on_o)
    else $error("soft reset left an enable set");

  chk_tx_enable_write: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_ctrl_wr ##0 !reg_wdata_i[B_SOFT_RST] |=>
      transmit_path_on_o == $past(reg_wdata_i[B_TX_ON]))
    else $error("transmit enable not taken from write");

  chk_rx_enable_write: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_ctrl_wr ##0 !reg_wdata_i[B_SOFT_RST] |=>
      receive_path_on_o == $past(reg_wdata_i[B_RX_ON]))
    else $error("receive enable not taken from write");

  chk_reset_low_zero: assert property (
    @(posedge clk_sys_i)
    !rst_n_i |=> ctrl_q[7:0] == 8'h00 && !gig_mode_o)
    else $error("control bits not zero after reset");

  chk_gig_forced: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ctrl_q[B_GIG] && !SMALL_MAC |=> gig_mode_o)
    else $error("gigabit select did not force gigabit");

  chk_gig_follows: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !ctrl_q[B_GIG] |=> gig_mode_o == $past(gig_request_i))
    else $error("gigabit mode did not follow request");

  chk_resume_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ctrl_q[B_TX_ON] && ctrl_q[B_RESUME] |=>
      pause_send_o && pause_quanta_o == RESUME_QUANTA)
    else $error("resume pause not sent with zero quanta");

  chk_reserved_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_ctrl_rd |=> reg_rdata_o[30:27] == 4'h0)
    else $error("reserved bits read nonzero");

  chk_accept_all: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    fire && rx_sop_i && ctrl_q[B_RX_ON] && ctrl_q[B_ACCEPT_ALL] |-> push)
    else $error("frame dropped while accepting all");

  chk_fcs_removed: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    fire && rx_is_fcs_i && !ctrl_q[B_FCS_KEEP] && !rx_eop_i |-> !push)
    else $error("check field passed while it should be removed");

  chk_padded_strip: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    fire && rx_is_fcs_i && padded_now && pad_strip_on |-> drop)
    else $error("check field kept in a stripped padded frame");
endmodule : mcc_ctrl

// ### verification/mcc_ctrl_tb_top.sv
// self-checking bench for the mac control word block
`timescale 1ns/100ps
module mcc_ctrl_tb_top;
  import mcc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, gig_request_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  logic rx_valid_i = 1'b0, rx_sop_i = 1'b0, rx_eop_i = 1'b0;
  logic rx_addr_hit_i = 1'b0, rx_is_pad_i = 1'b0, rx_is_fcs_i = 1'b0;
  logic rx_padded_i = 1'b0, usr_ready_i = 1'b1;
  logic [31:0] reg_rdata_o;
  logic [7:0] usr_data_o;
  logic [15:0] pause_quanta_o;
  logic rx_ready_o, usr_sop_o, usr_eop_o, usr_void_o, usr_valid_o;
  logic transmit_path_on_o, receive_path_on_o, gig_mode_o, pause_send_o;
  logic loopback_on_o, statistics_clear_o, ok;
  int error_cnt = 0;
  int tests_run = 0;
  logic [10:0] q[$];

  always #20 clk_sys_i = ~clk_sys_i;

  mcc_ctrl #(.SMALL_MAC(1'b0), .DEPTH(16), .STOP_AT(12)) u_mcc_ctrl (
    .clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .gig_request_i, .rx_data_i, .rx_valid_i, .rx_sop_i,
    .rx_eop_i, .rx_addr_hit_i, .rx_is_pad_i, .rx_is_fcs_i, .rx_padded_i,
    .rx_ready_o, .usr_data_o, .usr_sop_o, .usr_eop_o, .usr_void_o,
    .usr_valid_o, .usr_ready_i, .transmit_path_on_o, .receive_path_on_o,
    .gig_mode_o, .pause_send_o, .pause_quanta_o, .loopback_on_o,
    .statistics_clear_o
  );

  // words handed to the user side
  always @(posedge clk_sys_i) begin
    if (rst_n_i && usr_valid_o === 1'b1 && usr_ready_i) begin
      q.push_back({usr_sop_o, usr_eop_o, usr_void_o,
                   usr_void_o ? 8'h00 : usr_data_o});
    end
  end

  task automatic summarize;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(reg_rdata_o, e);
    @(negedge clk_sys_i);
    chk(reg_rdata_o, 32'h0000_0000);
    @(posedge clk_sys_i);
  endtask : rd

  task automatic send(input logic [7:0] d, input logic s, e, p, f);
    rx_data_i <= d;
    rx_sop_i <= s;
    rx_eop_i <= e;
    rx_is_pad_i <= p;
    rx_is_fcs_i <= f;
    rx_valid_i <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      ok = rx_ready_o;
      @(posedge clk_sys_i);
    end while (ok !== 1'b1);
  endtask : send

  task automatic frame(input logic [31:0] cfg, input logic hit, pd,
                       input int n, input logic [10:0] e0, e1, e2);
    logic [10:0] e[3];
    e = '{e0, e1, e2};
    q.delete();
    wr(CTRL_IDX, cfg);
    rx_addr_hit_i <= hit;
    rx_padded_i <= pd;
    send(8'h11, 1'b1, 1'b0, 1'b0, 1'b0);
    send(8'h22, 1'b0, 1'b0, 1'b1, 1'b0);
    send(8'h33, 1'b0, 1'b1, 1'b0, 1'b1);
    rx_valid_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chk(32'(q.size()), 32'(n));
    for (int i = 0; i < n; i++) begin
      chk(32'(q[i]), 32'(e[i]));
    end
  endtask : frame

  initial begin
    repeat (3000) @(posedge clk_sys_i);
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(negedge clk_sys_i);
    chk({30'h0, transmit_path_on_o, receive_path_on_o}, 32'h0);
    chk({16'h0, pause_quanta_o}, {16'h0, STOP_QUANTA});
    @(posedge clk_sys_i);
    rd(CTRL_IDX, 32'h0000_0000);
    wr(CTRL_IDX, 32'h0000_007c);
    @(negedge clk_sys_i);
    chk({30'h0, transmit_path_on_o, receive_path_on_o}, 32'h0);
    @(posedge clk_sys_i);
    rd(CTRL_IDX, 32'h0000_007c);
    wr(CTRL_IDX, 32'h0000_007f);
    @(negedge clk_sys_i);
    chk(32'(transmit_path_on_o), 32'h1);
    chk(32'(receive_path_on_o), 32'h1);
    @(posedge clk_sys_i);
    rd(6'h03, 32'h0000_0000);
    wr(CTRL_IDX, 32'hffff_ffff);
    @(negedge clk_sys_i);
    chk({30'h0, transmit_path_on_o, receive_path_on_o}, 32'h0);
    chk(32'(statistics_clear_o), 32'h1);
    chk(32'(loopback_on_o), 32'h1);
    @(posedge clk_sys_i);
    rd(CTRL_IDX, 32'h07ff_dffc);
    for (int i = 0; i < 4; i++) begin
      gig_request_i <= i[0];
      wr(CTRL_IDX, {28'h0, i[1], 3'b000});
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk(32'(gig_mode_o), 32'(i[1] | i[0]));
      @(posedge clk_sys_i);
    end
    wr(CTRL_IDX, 32'h0000_0005);
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(32'(pause_send_o), 32'h1);
    chk({16'h0, pause_quanta_o}, {16'h0, RESUME_QUANTA});
    @(posedge clk_sys_i);
    frame(32'h23, 1'b0, 1'b0, 0, 11'h0, 11'h0, 11'h0);
    frame(32'h33, 1'b0, 1'b0, 2, 11'h411, 11'h300, 11'h0);
    frame(32'h53, 1'b1, 1'b0, 3, 11'h411, 11'h022, 11'h233);
    frame(32'h73, 1'b1, 1'b1, 2, 11'h411, 11'h300, 11'h0);
    frame(32'h01, 1'b1, 1'b0, 0, 11'h0, 11'h0, 11'h0);
    q.delete();
    usr_ready_i <= 1'b0;
    wr(CTRL_IDX, 32'h0000_0013);
    for (int i = 0; i < 16; i++) begin
      send(8'(i), 1'(i == 0), 1'b0, 1'b0, 1'b0);
    end
    rx_valid_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(32'(rx_ready_o), 32'h0);
    chk(32'(pause_send_o), 32'h1);
    chk({16'h0, pause_quanta_o}, {16'h0, STOP_QUANTA});
    @(posedge clk_sys_i);
    usr_ready_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    chk(32'(q.size()), 32'd16);
    chk(32'(q[15]), 32'h0000_000f);
    send(8'h10, 1'b0, 1'b1, 1'b0, 1'b0);
    rx_valid_i <= 1'b0;
    wr(CTRL_IDX, 32'h0000_0003);
    rst_n_i <= 1'b0;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk({30'h0, transmit_path_on_o, receive_path_on_o}, 32'h0);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(CTRL_IDX, 32'h0000_0000);
    summarize();
  end
endmodule : mcc_ctrl_tb_top
